// File: src/cpm_pkg.sv
// Functional notes
// R1 - idle bit write halts cpu after instruction
// R2 - idle keeps state, peripherals keep clocks
// R3 - enabled interrupt ends idle, cpu resumes
// R4 - reset during idle restarts at zero
// R5 - watchdog counts in idle, overflow resets
// R6 - stop bit halts cpu, oscillator, clocks
// R7 - only reset ends stop, not interrupts
// R8 - detector resets after 100 us absence
// R9 - software shuts analog parts before stop
// R10 - mode select bits always read zero
// R11 - bit seven bypasses uart a halver
// R12 - bit four bypasses uart b halver
// R13 - bit six selects uart a status view
// R14 - bit three selects uart b status view
// R15 - reserved bits written zero, read zero
// R16 - after reset: 2 MHz oscillator, watchdog on (here the watchdog runs only while i_wdt_enable is high)
// R17 - both mode bits set means stop
package cpm_pkg;
   localparam logic [7:0] CPM_POWER_CONTROL_ADDR = 8'h87; // register address
   localparam logic [7:0] CPM_POWER_CONTROL_RST  = 8'h00; // reset value
   localparam int CPM_IDLE_BIT      = 0;
   localparam int CPM_STOP_BIT      = 1;
   localparam int CPM_RSVD_LO_BIT   = 2;
   localparam int CPM_B_VIEW_BIT    = 3;
   localparam int CPM_B_DOUBLER_BIT = 4;
   localparam int CPM_RSVD_HI_BIT   = 5;
   localparam int CPM_A_VIEW_BIT    = 6;
   localparam int CPM_A_DOUBLER_BIT = 7;
   // only these bits are stored; mode and reserved bits read zero
   localparam logic [7:0] CPM_STORED_MASK = 8'hd8;
   localparam int CPM_CLOCK_MHZ        = 100;   // core clock rate
   localparam int CPM_MCD_TIMEOUT_US   = 100;   // missing clock timeout
   localparam int CPM_MCD_CYCLES = CPM_MCD_TIMEOUT_US * CPM_CLOCK_MHZ;
   localparam int CPM_RESET_OSC_MHZ    = 2;     // default oscillator rate
   localparam int CPM_WDT_BITS         = 21;    // watchdog timer width
   // power mode state, one-hot
   typedef enum logic [2:0]
   {
      CPM_RUN  = 3'b001,
      CPM_IDLE = 3'b010,
      CPM_STOP = 3'b100
   } cpm_mode_e;
   // uart controls carried together
   typedef struct packed
   {
      logic a_doubler;
      logic a_view;
      logic b_doubler;
      logic b_view;
   } cpm_uart_s;
endpackage

// File: src/cpm_core_power_mode_control.sv
`timescale 1ns/1ps
module cpm_core_power_mode_control
#(
   parameter int MCD_CYCLES = cpm_pkg::CPM_MCD_CYCLES, // detector timeout
   parameter int WDT_BITS   = cpm_pkg::CPM_WDT_BITS    // watchdog width
)
(
   input  wire logic             i_clock,         // core clock
   input  wire logic             i_rst_n,         // system reset, sync
   input  wire logic             i_sfr_wr,        // sfr write strobe
   input  wire logic             i_sfr_rd,        // sfr read strobe
   input  wire logic [7:0]       i_sfr_addr,      // sfr address
   input  wire logic [7:0]       i_sfr_wdata,     // sfr write data
   input  wire logic             i_instr_done,    // instruction completes
   input  wire logic             i_irq_enabled,   // enabled irq pending
   input  wire logic             i_wdt_enable,    // watchdog enabled
   input  wire logic             i_wdt_kick,      // watchdog restart
   input  wire logic             i_mcd_enable,    // missing clock det on
   input  wire logic             i_ext_reset,     // external reset req
   output logic [7:0]            o_sfr_rdata,     // sfr read data
   output logic                  o_sfr_hit,       // address matched
   output logic                  o_cpu_clk_en,    // cpu clock enable
   output logic                  o_periph_clk_en, // peripheral clk enable
   output logic                  o_osc_en,        // internal osc enable
   output logic                  o_osc_2mhz_sel,  // default 2 MHz osc
   output logic                  o_idle,          // in idle
   output logic                  o_stop,          // in stop
   output logic                  o_wdt_reset,     // watchdog reset pulse
   output logic                  o_mcd_reset,     // detector reset pulse
   output logic                  o_int_reset,     // internal reset pulse
   output logic                  o_restart_zero,  // restart at 0x0000
   output cpm_pkg::cpm_uart_s    o_uart           // uart controls
);
   // refuse sizes the counters cannot hold; the detector compare is a
   // 32-bit value and a wider watchdog would never trip in practice
   if (MCD_CYCLES < 1 || WDT_BITS < 2 || WDT_BITS > 31)
   begin
      $error("cpm: illegal parameter");
   end

   cpm_pkg::cpm_mode_e    mode_r;          // power mode state
   logic [7:0]            pctl_r;          // stored control bits
   logic                  idle_req_r;      // idle pending to completion
   logic                  stop_req_r;      // stop pending to completion
   logic [WDT_BITS-1:0]   wdt_cnt_r;       // watchdog counter
   logic [31:0]           mcd_cnt_r;       // clock-absence timer
   logic                  wdt_ovf_r;       // watchdog overflow pulse
   logic                  mcd_ovf_r;       // detector timeout pulse
   logic                  reset_evt;       // any internal/external reset
   logic                  pctl_wr;         // decoded write
   // one at the counter's own width keeps the increment width-exact
   localparam logic [WDT_BITS-1:0] WDT_ONE = {{(WDT_BITS-1){1'b0}}, 1'b1};

   // any reset source clears state just like the system reset
   assign pctl_wr   = i_sfr_wr &&
                      (i_sfr_addr == cpm_pkg::CPM_POWER_CONTROL_ADDR);
   assign reset_evt = i_ext_reset || wdt_ovf_r || mcd_ovf_r;

   // control bits; mode and reserved bits never stored
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || reset_evt)
         pctl_r <= cpm_pkg::CPM_POWER_CONTROL_RST;
      else if (pctl_wr)
         pctl_r <= i_sfr_wdata & cpm_pkg::CPM_STORED_MASK; // [R15] [R10]
   end

   // pending mode requests wait for the writing instruction to end
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || reset_evt)
      begin
         idle_req_r <= 1'b0;
         stop_req_r <= 1'b0;
      end
      else if (pctl_wr)
      begin
         // stop wins when both are set [R17]
         stop_req_r <= i_sfr_wdata[cpm_pkg::CPM_STOP_BIT];
         idle_req_r <= i_sfr_wdata[cpm_pkg::CPM_IDLE_BIT] &&
                       !i_sfr_wdata[cpm_pkg::CPM_STOP_BIT];
      end
      else if (i_instr_done)
      begin
         idle_req_r <= 1'b0;
         stop_req_r <= 1'b0;
      end
   end

   // power mode machine
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || reset_evt)
         mode_r <= cpm_pkg::CPM_RUN; // reset ends any mode [R4] [R7]
      else
      begin
         unique case (mode_r)
            cpm_pkg::CPM_RUN:
            begin
               // entry on completion of the writing instruction
               if (stop_req_r && i_instr_done)
                  mode_r <= cpm_pkg::CPM_STOP; // [R6]
               else if (idle_req_r && i_instr_done)
                  mode_r <= cpm_pkg::CPM_IDLE; // [R1]
            end
            cpm_pkg::CPM_IDLE:
            begin
               // interrupt wakes; cpu resumes after the idle write [R3]
               if (i_irq_enabled)
                  mode_r <= cpm_pkg::CPM_RUN;
            end
            cpm_pkg::CPM_STOP:
            begin
               // interrupts ignored; only reset leaves [R7]
               mode_r <= cpm_pkg::CPM_STOP;
            end
         endcase
      end
   end

   // watchdog keeps counting in idle, frozen in stop [R5]
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || reset_evt || i_wdt_kick || !i_wdt_enable)
         wdt_cnt_r <= '0;
      else if (mode_r != cpm_pkg::CPM_STOP)
         wdt_cnt_r <= wdt_cnt_r + WDT_ONE;
   end

   // overflow pulse forces internal reset [R5]
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         wdt_ovf_r <= 1'b0;
      else
         wdt_ovf_r <= (mode_r != cpm_pkg::CPM_STOP) && i_wdt_enable &&
                      !i_wdt_kick && (&wdt_cnt_r) && !wdt_ovf_r;
   end

   // clock-absence timer: in stop the system clock is gone, so the
   // detector's own one-shot is modelled as this count [R8]
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || reset_evt || mode_r != cpm_pkg::CPM_STOP ||
          !i_mcd_enable)
         mcd_cnt_r <= '0;
      else if (mcd_cnt_r < 32'(MCD_CYCLES))
         mcd_cnt_r <= mcd_cnt_r + 32'h1;
   end

   // timeout pulse once absence passes the limit [R8]
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         mcd_ovf_r <= 1'b0;
      else
         mcd_ovf_r <= i_mcd_enable && (mode_r == cpm_pkg::CPM_STOP) &&
                      (mcd_cnt_r == 32'(MCD_CYCLES) - 32'h1) && !mcd_ovf_r;
   end

   // registered read data; mode bits always zero [R10]
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         o_sfr_rdata <= 8'h00;
      else if (i_sfr_rd && i_sfr_addr == cpm_pkg::CPM_POWER_CONTROL_ADDR)
         o_sfr_rdata <= pctl_r & cpm_pkg::CPM_STORED_MASK; // [R10] [R15]
      else
         o_sfr_rdata <= 8'h00;
   end

   // reset restart indication: pc to zero, 2 MHz osc default [R16] [R4]
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         o_restart_zero <= 1'b1;
      else
         o_restart_zero <= reset_evt;
   end

   assign o_sfr_hit       = i_sfr_addr == cpm_pkg::CPM_POWER_CONTROL_ADDR;
   // idle gates only the cpu; peripherals and state keep running [R2]
   assign o_cpu_clk_en    = mode_r == cpm_pkg::CPM_RUN;
   assign o_periph_clk_en = mode_r != cpm_pkg::CPM_STOP;        // [R6]
   assign o_osc_en        = mode_r != cpm_pkg::CPM_STOP;        // [R6]
   assign o_osc_2mhz_sel  = 1'b1;                               // [R16]
   assign o_idle          = mode_r == cpm_pkg::CPM_IDLE;
   assign o_stop          = mode_r == cpm_pkg::CPM_STOP;
   assign o_wdt_reset     = wdt_ovf_r;
   assign o_mcd_reset     = mcd_ovf_r;
   assign o_int_reset     = wdt_ovf_r || mcd_ovf_r;
   // uart controls straight from stored bits [R11] [R12] [R13] [R14]
   assign o_uart.a_doubler = pctl_r[cpm_pkg::CPM_A_DOUBLER_BIT];
   assign o_uart.a_view    = pctl_r[cpm_pkg::CPM_A_VIEW_BIT];
   assign o_uart.b_doubler = pctl_r[cpm_pkg::CPM_B_DOUBLER_BIT];
   assign o_uart.b_view    = pctl_r[cpm_pkg::CPM_B_VIEW_BIT];

   // idle entry after completing instruction
   idle_entry_a: assert property ( // [R1]
      @(posedge i_clock) disable iff (!i_rst_n)
      (mode_r == cpm_pkg::CPM_RUN && idle_req_r && i_instr_done &&
       !reset_evt) |=> o_idle && !o_cpu_clk_en && o_periph_clk_en)
      else $error("idle not entered");

   // interrupt wakes idle
   idle_wake_a: assert property ( // [R3]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_idle && i_irq_enabled) |=> o_cpu_clk_en)
      else $error("idle not woken");

   // idle holds without interrupt; peripherals and register kept
   idle_keep_a: assert property ( // [R2]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_idle && !i_irq_enabled && !reset_evt && !pctl_wr)
      |=> o_idle && o_periph_clk_en && o_osc_en && $stable(pctl_r))
      else $error("idle state not kept");

   // watchdog advances every cycle of idle
   wdt_count_a: assert property ( // [R5]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_idle && i_wdt_enable && !i_wdt_kick && !reset_evt)
      |=> wdt_cnt_r == $past(wdt_cnt_r) + WDT_ONE)
      else $error("watchdog stalled in idle");

   // stop entry stops oscillator
   stop_entry_a: assert property ( // [R6]
      @(posedge i_clock) disable iff (!i_rst_n)
      (mode_r == cpm_pkg::CPM_RUN && stop_req_r && i_instr_done &&
       !reset_evt) |=> o_stop && !o_osc_en && !o_periph_clk_en)
      else $error("stop not entered");

   // watchdog halts with the system clock in stop
   wdt_frozen_a: assert property ( // [R6]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_stop && !reset_evt && i_wdt_enable && !i_wdt_kick)
      |=> $stable(wdt_cnt_r))
      else $error("watchdog ran in stop");

   // interrupts cannot wake stop
   stop_hold_a: assert property ( // [R7]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_stop && !reset_evt) |=> o_stop)
      else $error("stop left without reset");

   // reset always returns to run
   reset_run_a: assert property ( // [R4]
      @(posedge i_clock) disable iff (!i_rst_n)
      reset_evt |=> o_cpu_clk_en && o_restart_zero)
      else $error("reset did not restart");

   // any reset restores the 2 MHz default and an empty register
   restart_osc_a: assert property ( // [R16]
      @(posedge i_clock) disable iff (!i_rst_n)
      reset_evt |=> o_osc_2mhz_sel && o_restart_zero &&
      pctl_r == cpm_pkg::CPM_POWER_CONTROL_RST)
      else $error("reset defaults not restored");

   // mode bits read zero
   read_zero_a: assert property ( // [R10]
      @(posedge i_clock) disable iff (!i_rst_n)
      o_sfr_rdata[1:0] == 2'b00 && o_sfr_rdata[5] == 1'b0 &&
      o_sfr_rdata[2] == 1'b0)
      else $error("mode bit read nonzero");

   // read data idles at zero between reads
   rdata_idle_a: assert property ( // [R10]
      @(posedge i_clock) disable iff (!i_rst_n)
      !(i_sfr_rd && o_sfr_hit) |=> o_sfr_rdata == 8'h00)
      else $error("read data not cleared");

   // both bits set gives stop
   both_stop_a: assert property ( // [R17]
      @(posedge i_clock) disable iff (!i_rst_n)
      (pctl_wr && i_sfr_wdata[1:0] == 2'b11 && !reset_evt)
      |=> stop_req_r && !idle_req_r)
      else $error("combined write not stop");

   // detector fires after timeout in stop
   mcd_fire_a: assert property ( // [R8]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_mcd_reset) |-> $past(mcd_cnt_r) == 32'(MCD_CYCLES) - 32'h1)
      else $error("detector timing wrong");

   // a disabled detector never resets
   mcd_quiet_a: assert property ( // [R8]
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_mcd_enable |=> !o_mcd_reset)
      else $error("detector fired while off");

   // uart doublers follow write
   uart_ctl_a: assert property ( // [R11] [R12]
      @(posedge i_clock) disable iff (!i_rst_n)
      (pctl_wr && !reset_evt) |=> o_uart.a_doubler == $past(i_sfr_wdata[7])
      && o_uart.b_doubler == $past(i_sfr_wdata[4]))
      else $error("doubler not stored");

   // uart status views follow write
   uart_view_a: assert property ( // [R13] [R14]
      @(posedge i_clock) disable iff (!i_rst_n)
      (pctl_wr && !reset_evt) |=>
      o_uart.a_view == $past(i_sfr_wdata[cpm_pkg::CPM_A_VIEW_BIT]) &&
      o_uart.b_view == $past(i_sfr_wdata[cpm_pkg::CPM_B_VIEW_BIT]))
      else $error("status view not stored");

   // watchdog overflow resets from idle
   wdt_idle_a: assert property ( // [R5]
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_wdt_reset) |=> !o_idle && o_cpu_clk_en)
      else $error("watchdog did not end idle");
endmodule

// File: sim/test_core_power_mode_control.sv
`timescale 1ns/1ps
module test_core_power_mode_control;
   localparam int MISSING_CLOCK_DETECTOR = 20; // short detector timeout keeps the run brief
   localparam int WDT = 6;  // watchdog overflows after 64 counts
   logic               i_clock, i_rst_n, i_sfr_wr, i_sfr_rd;
   logic               i_instr_done, i_irq_enabled, i_wdt_enable;
   logic               i_wdt_kick, i_mcd_enable, i_ext_reset;
   logic [7:0]         i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
   logic               o_sfr_hit, o_cpu_clk_en, o_periph_clk_en, o_osc_en;
   logic               o_osc_2mhz_sel, o_idle, o_stop, o_wdt_reset;
   logic               o_mcd_reset, o_int_reset, o_restart_zero;
   cpm_pkg::cpm_uart_s o_uart;            // uart controls seen at the port
   int                 fail_count, compares, n;
   logic [7:0]         pat [4];           // uart field patterns, no mode bits
   // block under test, counts shortened
   cpm_core_power_mode_control #(.MCD_CYCLES(MISSING_CLOCK_DETECTOR), .WDT_BITS(WDT)) DUT
   (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sfr_wr(i_sfr_wr),
      .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
      .i_sfr_wdata(i_sfr_wdata), .i_instr_done(i_instr_done),
      .i_irq_enabled(i_irq_enabled), .i_wdt_enable(i_wdt_enable),
      .i_wdt_kick(i_wdt_kick), .i_mcd_enable(i_mcd_enable),
      .i_ext_reset(i_ext_reset), .o_sfr_rdata(o_sfr_rdata),
      .o_sfr_hit(o_sfr_hit), .o_cpu_clk_en(o_cpu_clk_en),
      .o_periph_clk_en(o_periph_clk_en), .o_osc_en(o_osc_en),
      .o_osc_2mhz_sel(o_osc_2mhz_sel), .o_idle(o_idle), .o_stop(o_stop),
      .o_wdt_reset(o_wdt_reset), .o_mcd_reset(o_mcd_reset),
      .o_int_reset(o_int_reset), .o_restart_zero(o_restart_zero),
      .o_uart(o_uart)
   );
   // free running 100 MHz clock
   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   // byte compare, case equality so unknowns never match
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // single flag compare
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   // one edge, then settle; inputs always change 1 ns after the edge
   task automatic step;
      @(posedge i_clock);
      #1;
   endtask
   // sfr write, taken at one edge
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      i_sfr_wr = 1'b1;
      i_sfr_addr = a;
      i_sfr_wdata = d;
      step;
      i_sfr_wr = 1'b0;
   endtask
   // sfr read, data registered at the taking edge
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
      i_sfr_rd = 1'b1;
      i_sfr_addr = a;
      step;
      i_sfr_rd = 1'b0;
      chk_byte(o_sfr_rdata, e);
   endtask
   // instruction completes; must follow the write by at least one edge
   task automatic pulse_done;
      i_instr_done = 1'b1;
      step;
      i_instr_done = 1'b0;
   endtask
   // one cycle external reset request
   task automatic pulse_ext;
      i_ext_reset = 1'b1;
      step;
      i_ext_reset = 1'b0;
   endtask
   // verdict and end of run
   task automatic print_verdict;
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far beyond the fewer than 200 cycles the tests need
   initial
   begin
      #100000;
      fail_count++;
      print_verdict;
   end
   // main sequence
   initial
   begin
      {i_rst_n, i_sfr_wr, i_sfr_rd, i_instr_done, i_irq_enabled} = 5'h00;
      {i_wdt_enable, i_wdt_kick, i_mcd_enable, i_ext_reset} = 4'h0;
      i_sfr_addr = 8'h00;
      i_sfr_wdata = 8'h00;
      fail_count = 0;
      compares = 0;
      pat = '{8'h90, 8'h48, 8'h00, 8'hd8};
      repeat (5) @(posedge i_clock);
      #1;
      chk_bit(o_restart_zero, 1'b1);
      chk_bit(o_osc_2mhz_sel, 1'b1);
      i_rst_n = 1'b1;
      sfr_rd(8'h87, 8'h00);
      // every uart field on and off; mode and reserved bits read zero
      for (int k = 0; k < 4; k++)
      begin
         sfr_wr(8'h87, pat[k]); // reserved bits written zero
         sfr_rd(8'h87, pat[k] & cpm_pkg::CPM_STORED_MASK);
         chk_bit(o_sfr_hit, 1'b1);
         chk_bit(o_uart.a_doubler, pat[k][7]);
         chk_bit(o_uart.b_doubler, pat[k][4]);
         chk_bit(o_uart.a_view, pat[k][6]);
         chk_bit(o_uart.b_view, pat[k][3]);
      end
      sfr_wr(8'h88, 8'h00); // other address leaves the register
      chk_bit(o_sfr_hit, 1'b0);
      sfr_rd(8'h87, 8'hd8);
      // idle entry on completion, wake by interrupt
      sfr_wr(8'h87, 8'h81);
      pulse_done;
      chk_byte({o_idle, o_cpu_clk_en, o_periph_clk_en, o_osc_en},
               8'h0b);
      sfr_rd(8'h87, 8'h80);
      i_irq_enabled = 1'b1;
      step;
      i_irq_enabled = 1'b0;
      chk_byte({o_idle, o_cpu_clk_en, o_restart_zero}, 8'h02);
      sfr_rd(8'h87, 8'h80);
      // idle ended by external reset
      sfr_wr(8'h87, 8'h01);
      pulse_done;
      pulse_ext;
      chk_byte({o_idle, o_restart_zero}, 8'h01);
      sfr_rd(8'h87, 8'h00);
      // watchdog keeps counting in idle and resets
      i_wdt_enable = 1'b1;
      i_wdt_kick = 1'b1;
      step;
      i_wdt_kick = 1'b0;
      sfr_wr(8'h87, 8'h01);
      pulse_done;
      chk_bit(o_idle, 1'b1);
      for (n = 0; n < 200 && o_wdt_reset !== 1'b1; n++)
         step;
      chk_bit(n >= (1 << WDT) - 4 && n <= (1 << WDT) &&
              o_int_reset === 1'b1, 1'b1);
      step;
      i_wdt_enable = 1'b0;
      chk_byte({o_idle, o_restart_zero}, 8'h01);
      // both mode bits: stop wins, interrupts ignored, detector off
      sfr_wr(8'h87, 8'h03); // analog parts modelled as off
      pulse_done;
      chk_byte({o_stop, o_cpu_clk_en, o_periph_clk_en, o_osc_en},
               8'h08);
      i_irq_enabled = 1'b1;
      repeat (3 * MISSING_CLOCK_DETECTOR) step;
      i_irq_enabled = 1'b0;
      chk_bit(o_stop, 1'b1);
      pulse_ext;
      chk_byte({o_stop, o_restart_zero}, 8'h01);
      // detector times out in stop and resets
      i_mcd_enable = 1'b1;
      sfr_wr(8'h87, 8'h02);
      pulse_done;
      for (n = 0; n < 200 && o_mcd_reset !== 1'b1; n++)
         step;
      chk_bit(n >= MISSING_CLOCK_DETECTOR && n <= MISSING_CLOCK_DETECTOR + 2 && o_int_reset === 1'b1, 1'b1);
      step;
      i_mcd_enable = 1'b0;
      chk_byte({o_stop, o_restart_zero}, 8'h01);
      // system reset in mid-run clears the register again
      sfr_wr(8'h87, 8'hd8);
      i_rst_n = 1'b0;
      step;
      chk_bit(o_restart_zero, 1'b1);
      i_rst_n = 1'b1;
      sfr_rd(8'h87, 8'h00);
      chk_bit(o_uart.a_doubler, 1'b0);
      print_verdict;
   end
endmodule
